// ---- tec_capture.sv ----
`default_nettype none

// Overview of operation
// - No dedicated record for interrupt entry.
// - Return address push logged before vector fetch.
// - Acknowledge flag set in interrupted cycle.
// - Multi-cycle instruction finishes, then push, vector.
// - Log external, brown-out and watchdog resets; of resets rising together, only the first listed.
// - Log sleep entry in every sleep mode.
// - Time stamp keeps counting during sleep.
// - One sleep record per sleeping cycle without a reset rise.
package tec_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STAMP_W = 48;
  localparam int ADDR_W = 22;
  localparam int KIND_W = 3;
  localparam int BUF_DEPTH = 4;
  localparam logic [STAMP_W-1:0] STAMP_RST = 48'h0000_0000_0000;
  localparam logic [STAMP_W-1:0] STAMP_STEP = 48'h0000_0000_0001;
  // Record kinds; interrupt entry deliberately has no kind of its own.
  typedef enum logic [KIND_W-1:0] {
    TEC_K_EXEC = 3'h0,
    TEC_K_PUSH = 3'h1,
    TEC_K_SLEEP = 3'h2,
    TEC_K_RST_EXT = 3'h3,
    TEC_K_RST_BOD = 3'h4,
    TEC_K_RST_WDT = 3'h5
  } tec_kind_e;
endpackage : tec_pkg

////////////////////////////////////////////////////////////////////////////////
// Per-cycle trace capture: turns core execution state into buffered records.
module tec_capture import tec_pkg::*; #(
  parameter int DEPTH = BUF_DEPTH
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Trace enable from the host side, asynchronous to the core clock.
  input wire logic trace_en,
  // Per-cycle execution state from the emulated core.
  input wire logic core_valid,
  input wire logic [ADDR_W-1:0] core_addr,
  input wire logic interrupt_ack_flag,
  input wire logic core_push_pc,
  input wire logic core_sleep,
  input wire logic core_reset_ext,
  input wire logic brownout_detect_reset,
  input wire logic core_reset_wdt,
  output logic core_stall,
  // Trace buffer drain side.
  output logic rec_valid,
  output logic [STAMP_W-1:0] rec_stamp,
  output logic [ADDR_W-1:0] rec_addr,
  output tec_kind_e rec_kind,
  output logic rec_ia,
  input wire logic rec_ready,
  // Sticky flag: a record was lost because the buffer was stalled.
  output logic trace_drop
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int RW = STAMP_W + ADDR_W + KIND_W + 1;
  // Wide enough for the buffer's whole content plus the staged record.
  localparam int HW = $clog2(DEPTH + 3);

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic [2:0] rst_prev;
    logic [STAMP_W-1:0] stamp;
    logic wr_valid;
    logic [RW-1:0] wr_data;
    logic stall;
    logic drop;
    logic irq_pend;
    logic [HW-1:0] held;
  } tec_cap_s;

  tec_cap_s s_r;
  tec_cap_s s_nxt;
  logic fifo_in_ready;
  logic accepted;
  logic ev;
  tec_kind_e ev_kind;
  logic [RW-1:0] fifo_out;
  logic [2:0] rst_now;

  // Reset levels of this cycle, status flags and record fields unpacked from the buffer output.
  assign rst_now = {core_reset_ext, brownout_detect_reset, core_reset_wdt};
  assign core_stall = s_r.stall;
  assign trace_drop = s_r.drop;
  assign rec_stamp = fifo_out[RW-1 -: STAMP_W];
  assign rec_addr = fifo_out[ADDR_W+KIND_W:KIND_W+1];
  assign rec_kind = tec_kind_e'(fifo_out[KIND_W:1]);
  assign rec_ia = fifo_out[0];

  ////////////////////////////////////////////////////////////////////////////////
  // Event selection and record build; resets take priority over sleep and execution.
  always_comb begin
    s_nxt = s_r;
    s_nxt.en_s1 = trace_en;
    s_nxt.en_s2 = s_r.en_s1;
    s_nxt.rst_prev = rst_now;
    s_nxt.stamp = s_r.stamp + STAMP_STEP;
    accepted = s_r.wr_valid && fifo_in_ready;
    ev = 1'b0;
    ev_kind = TEC_K_EXEC;
    if (s_r.en_s2) begin
      if (core_reset_ext && !s_r.rst_prev[2]) begin
        ev = 1'b1;
        ev_kind = TEC_K_RST_EXT;
      end else if (brownout_detect_reset && !s_r.rst_prev[1]) begin
        ev = 1'b1;
        ev_kind = TEC_K_RST_BOD;
      end else if (core_reset_wdt && !s_r.rst_prev[0]) begin
        ev = 1'b1;
        ev_kind = TEC_K_RST_WDT;
      end else if (core_sleep) begin
        ev = 1'b1;
        ev_kind = TEC_K_SLEEP;
      end else if (core_push_pc) begin
        ev = 1'b1;
        ev_kind = TEC_K_PUSH;
      end else if (core_valid) begin
        ev = 1'b1;
        ev_kind = TEC_K_EXEC;
      end
    end
    if (accepted) begin
      s_nxt.wr_valid = 1'b0;
    end
    // Records are written strictly in arrival order, so push precedes the vector.
    if (ev) begin
      if (!s_r.wr_valid || accepted) begin
        s_nxt.wr_valid = 1'b1;
        s_nxt.wr_data = {s_r.stamp, core_addr, ev_kind, interrupt_ack_flag};
      end else begin
        s_nxt.drop = 1'b1;
      end
    end
    // Interrupt window runs from the acknowledge until the return address push.
    if (interrupt_ack_flag) begin
      s_nxt.irq_pend = 1'b1;
    end else if (core_push_pc) begin
      s_nxt.irq_pend = 1'b0;
    end
    // Records held in the buffer, output stage included: up on entry, down when drained.
    s_nxt.held = s_r.held + HW'(accepted) - HW'(rec_valid && rec_ready);
    // Stall early: one more event may already be on its way before the core sees the request.
    s_nxt.stall = (HW'(s_nxt.wr_valid) + s_nxt.held) >= HW'(DEPTH);
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.stamp <= STAMP_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Trace buffer.
  tec_fifo #(
    .WIDTH(RW),
    .DEPTH(DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .in_valid(s_r.wr_valid),
    .in_data(s_r.wr_data),
    .in_ready(fifo_in_ready),
    .out_valid(rec_valid),
    .out_data(fifo_out),
    .out_ready(rec_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks beside the logic they guard.
  sequence seq_sleep_cycle;
    s_r.en_s2 && core_sleep && !(|(rst_now & ~s_r.rst_prev)) && (!s_r.wr_valid || accepted);
  endsequence

  AST_STAMP_STEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !sys_rst |=> s_r.stamp == $past(s_r.stamp) + STAMP_STEP) else $error("Time stamp did not step by one.");
  AST_STAMP_SLEEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
    core_sleep ##1 core_sleep |-> s_r.stamp != $past(s_r.stamp)) else $error("Time stamp froze in sleep.");
  AST_SLEEP_REC: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seq_sleep_cycle |=> s_r.wr_valid && s_r.wr_data[KIND_W:1] == TEC_K_SLEEP)
    else $error("Sleeping cycle left no sleep record.");
  AST_SLEEP_ENTRY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seq_sleep_cycle ##0 $rose(core_sleep) |=> s_r.wr_data[RW-1 -: STAMP_W] == $past(s_r.stamp))
    else $error("Sleep entry record carries wrong stamp.");
  AST_RST_EXT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_r.en_s2 && core_reset_ext && !s_r.rst_prev[2] && (!s_r.wr_valid || accepted)
    |=> s_r.wr_data[KIND_W:1] == TEC_K_RST_EXT) else $error("External reset not logged.");
  AST_RST_BOD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_r.en_s2 && !core_reset_ext && brownout_detect_reset && !s_r.rst_prev[1] && (!s_r.wr_valid || accepted)
    |=> s_r.wr_data[KIND_W:1] == TEC_K_RST_BOD) else $error("Brown-out reset not logged.");
  AST_IA_FLAG: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_r.en_s2 && core_valid && interrupt_ack_flag && !core_sleep && !core_push_pc && !(|rst_now)
    && (!s_r.wr_valid || accepted) |=> s_r.wr_data[0] && s_r.wr_data[KIND_W:1] == TEC_K_EXEC)
    else $error("Acknowledge flag missing or dedicated interrupt record written.");
  AST_PUSH_REC: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_r.en_s2 && core_push_pc && !core_sleep && !(|rst_now) && (!s_r.wr_valid || accepted)
    |=> s_r.wr_data[KIND_W:1] == TEC_K_PUSH && !s_r.irq_pend) else $error("Return address push not logged.");
  AST_OFF_QUIET: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !s_r.en_s2 && !s_r.wr_valid |=> !s_r.wr_valid) else $error("Record written while tracing is off.");

endmodule : tec_capture

`default_nettype wire

// ---- tec_fifo.sv ----
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Record buffer with a registered output stage, so the drain side sees flops only.
module tec_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Filling side.
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side.
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } tec_fifo_s;

  tec_fifo_s s_r;
  tec_fifo_s s_nxt;
  logic push;
  logic pop;

  // Ready on the filling side falls only when the store is full.
  assign in_ready = (s_r.cnt != FULL_CNT);
  assign out_valid = s_r.ov;
  assign out_data = s_r.od;

  // Store and forward; the output stage refills from a non-empty store when it is empty or taken.
  always_comb begin
    s_nxt = s_r;
    push = in_valid && in_ready;
    pop = (s_r.cnt != '0) && (!s_r.ov || out_ready);
    if (out_ready) begin
      s_nxt.ov = 1'b0;
    end
    if (pop) begin
      s_nxt.ov = 1'b1;
      s_nxt.od = s_r.mem[s_r.rp];
      s_nxt.rp = (s_r.rp == PW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == PW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
  end

  // State register.
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  AST_FIFO_NO_OVERRUN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_r.cnt <= FULL_CNT) else $error("Record buffer count above depth.");
  AST_FIFO_HOLD: assert property (@(posedge ref_clk) disable iff (sys_rst)
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("Buffered record changed before it was taken.");

endmodule : tec_fifo

`default_nettype wire

// ---- tec_core_model.sv ----
`default_nettype none

////////////////////////////////////////
// Behavioural emulated core: presents one cycle of execution state per step.
module tec_core_model import tec_pkg::*; (
  // Clock.
  input wire logic ref_clk,
  // Execution state towards the capture logic.
  output logic core_valid,
  output logic [ADDR_W-1:0] core_addr,
  output logic interrupt_ack_flag,
  output logic core_push_pc,
  output logic core_sleep,
  output logic core_reset_ext,
  output logic brownout_detect_reset,
  output logic core_reset_wdt
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle state at time zero.
  initial begin
    {core_valid, interrupt_ack_flag, core_push_pc, core_sleep} = 4'h0;
    {core_reset_ext, brownout_detect_reset, core_reset_wdt} = 3'h0;
    core_addr = 22'h000000;
  end

  // Drives one cycle just after an edge; flags are valid, ack, push, sleep, ext, brown-out, watchdog.
  task automatic step(input logic [6:0] f, input logic [ADDR_W-1:0] a);
    @(posedge ref_clk);
    {core_valid, interrupt_ack_flag, core_push_pc, core_sleep} <= f[6:3];
    {core_reset_ext, brownout_detect_reset, core_reset_wdt} <= f[2:0];
    core_addr <= a;
  endtask : step
endmodule : tec_core_model

`default_nettype wire

// ---- tec_testbench.sv ----
`default_nettype none
`define TEC_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

////////////////////////////////////////
// Self-checking bench: a driver notes expected records, a monitor compares them.
module testbench import tec_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trace_en = 1'b1;
  logic rec_ready = 1'b0;
  logic rnd_on = 1'b0;
  logic chk_on = 1'b1;
  logic obey_stall = 1'b1;
  logic core_valid, interrupt_ack_flag, core_push_pc, core_sleep;
  logic core_reset_ext, brownout_detect_reset, core_reset_wdt;
  logic core_stall, rec_valid, rec_ia, trace_drop;
  logic [ADDR_W-1:0] core_addr, rec_addr, a;
  logic [STAMP_W-1:0] rec_stamp;
  logic [STAMP_W-1:0] stamp_m = 48'h0;
  tec_kind_e rec_kind;
  logic [2:0] rst_prev = 3'h0;
  logic [73:0] exp_q[$];
  logic [73:0] exp_r;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;

  tec_core_model tec_core_model_i (.ref_clk(ref_clk), .core_valid(core_valid), .core_addr(core_addr),
    .interrupt_ack_flag(interrupt_ack_flag), .core_push_pc(core_push_pc), .core_sleep(core_sleep),
    .core_reset_ext(core_reset_ext), .brownout_detect_reset(brownout_detect_reset),
    .core_reset_wdt(core_reset_wdt));
  tec_capture #(.DEPTH(BUF_DEPTH)) tec_capture_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .trace_en(trace_en),
    .core_valid(core_valid), .core_addr(core_addr), .interrupt_ack_flag(interrupt_ack_flag),
    .core_push_pc(core_push_pc), .core_sleep(core_sleep), .core_reset_ext(core_reset_ext),
    .brownout_detect_reset(brownout_detect_reset), .core_reset_wdt(core_reset_wdt),
    .core_stall(core_stall), .rec_valid(rec_valid), .rec_stamp(rec_stamp), .rec_addr(rec_addr),
    .rec_kind(rec_kind), .rec_ia(rec_ia), .rec_ready(rec_ready), .trace_drop(trace_drop));

  // Clock, cycle-count stamp model, random drain stalls and the hang limit.
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    stamp_m <= sys_rst ? STAMP_RST : stamp_m + STAMP_STEP;
    rec_ready <= rnd_on & ($urandom_range(3) != 0);
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      summarize();
    end
  end

  // Monitor: each accepted record is compared with the oldest note.
  always @(posedge ref_clk) begin
    if (!sys_rst && chk_on && rec_valid === 1'b1 && rec_ready === 1'b1) begin
      exp_r = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      `TEC_CHK("record", exp_r, {rec_stamp, rec_addr, rec_kind, rec_ia})
    end
  end

  // Drives one core cycle and notes the record it should produce; resets count on a rising level.
  // The stall request is read 1 ns after the edge, once the design has updated it.
  task automatic ev(input logic [6:0] f, input logic [ADDR_W-1:0] ad);
    logic [2:0] rise;
    tec_kind_e k;
    #1;
    while (obey_stall && core_stall === 1'b1) begin
      tec_core_model_i.step({4'h0, rst_prev}, 22'($urandom));
      #1;
    end
    rise = f[2:0] & ~rst_prev;
    rst_prev = f[2:0];
    k = rise[2] ? TEC_K_RST_EXT : rise[1] ? TEC_K_RST_BOD : rise[0] ? TEC_K_RST_WDT :
      f[3] ? TEC_K_SLEEP : f[4] ? TEC_K_PUSH : TEC_K_EXEC;
    tec_core_model_i.step(f, ad);
    if (trace_en && ((|rise) || (|{f[6], f[4:3]}))) exp_q.push_back({stamp_m + STAMP_STEP, ad, k, f[5]});
  endtask : ev

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // Main sequence.
  initial begin
    void'($urandom(95));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rnd_on <= 1'b1;
    repeat (4) @(posedge ref_clk);
    for (int i = 0; i < 15; i++) ev((i % 5 >= 3) ? 7'h00 : 7'h40, 22'($urandom));
    for (int i = 0; i < 2; i++) begin
      a = 22'($urandom);
      ev(7'h60, a);
      ev(7'h40, a);
      ev(7'h10, a);
      ev(7'h40, 22'($urandom));
    end
    for (int i = 0; i < 5; i++) ev(7'h08, 22'($urandom));
    ev(7'h40, 22'($urandom));
    for (int r = 0; r < 3; r++) begin
      ev(7'h04 >> r, 22'($urandom));
      ev(7'h04 >> r, 22'($urandom));
      ev(7'h00, 22'($urandom));
    end
    ev(7'h4C, 22'($urandom));
    ev(7'h00, 22'($urandom));
    trace_en <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ev(7'h40, 22'($urandom));
    ev(7'h08, 22'($urandom));
    ev(7'h00, 22'($urandom));
    trace_en <= 1'b1;
    repeat (4) @(posedge ref_clk);
    ev(7'h40, 22'($urandom));
    ev(7'h00, 22'($urandom));
    for (int i = 0; i < 200 && exp_q.size() > 0; i++) @(posedge ref_clk);
    `TEC_CHK("notes left", 0, exp_q.size())
    `TEC_CHK("drop clear", 1'b0, trace_drop)
    // Overflow: the drain stalls and the core ignores the stall request.
    rnd_on <= 1'b0;
    obey_stall = 1'b0;
    repeat (2) @(posedge ref_clk);
    chk_on = 1'b0;
    for (int i = 0; i < 10; i++) ev(7'h40, 22'($urandom));
    ev(7'h00, 22'($urandom));
    @(posedge ref_clk);
    #1;
    `TEC_CHK("stall", 1'b1, core_stall)
    `TEC_CHK("drop set", 1'b1, trace_drop)
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `TEC_CHK("drop reset", 1'b0, trace_drop)
    `TEC_CHK("valid reset", 1'b0, rec_valid)
    summarize();
  end
endmodule : testbench

`default_nettype wire
